//--- verilog/sld_map.svh
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// ****************************************
// timing figures
// ****************************************
`define SLD_T_CLK_NS 25
`define SLD_T_SCK_NS 150
`define SLD_T_DATA_NS 150
`define SLD_T_GAP_NS 300
`define SLD_T_STB_NS 100
`define SLD_CYC_SCK ((`SLD_T_SCK_NS + `SLD_T_CLK_NS - 1) / `SLD_T_CLK_NS)
`define SLD_CYC_GAP ((`SLD_T_GAP_NS + `SLD_T_CLK_NS - 1) / `SLD_T_CLK_NS)
`define SLD_CYC_STB ((`SLD_T_STB_NS + `SLD_T_CLK_NS - 1) / `SLD_T_CLK_NS)
// strobe held well past its minimum and followed by a quiet tail, so a
// receiver that samples strobe through a slow synchroniser sees it settle
`define SLD_CYC_STB_HOLD (3 * `SLD_CYC_STB)
`define SLD_CYC_TAIL `SLD_CYC_GAP

// ****************************************
// sizes and reset values
// ****************************************
`define SLD_CHANNELS 8
`define SLD_CNT_W 5
`define SLD_SYNC_LEN 3
`define SLD_RST_BYTE 8'h00

`endif

//--- verilog/sld_pkg.sv
// ****************************************
// shared types
// ****************************************
package sld_pkg;

  typedef enum logic [2:0] {
    SLD_IDLE = 3'b000,
    SLD_LOW = 3'b001,
    SLD_HIGH = 3'b010,
    SLD_GAP = 3'b011,
    SLD_STROBE = 3'b100
  } sld_state_t;

endpackage : sld_pkg

//--- verilog/sld_if.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// serial link between controller and driver
// ****************************************
interface sld_if;
  logic sclk;   // serial shift clock, made by controller
  logic sdi;    // serial data into driver
  logic sdo;    // cascade output of last stage
  logic strobe; // latch transfer, level
  logic blank;  // high forces all drivers off

  modport ctl (
    output sclk,
    output sdi,
    output strobe,
    output blank,
    input sdo
  );

  modport dev (
    input sclk,
    input sdi,
    input strobe,
    input blank,
    output sdo
  );
endinterface : sld_if

`default_nettype wire

//--- verilog/sld_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "sld_map.svh"

// ****************************************
// latched output driver end
// ****************************************
module sld_device
  import sld_pkg::*;
#(
  parameter int CHANNELS = `SLD_CHANNELS
) (
  sld_if.dev link,
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [CHANNELS-1:0] drv_o
);

  logic [CHANNELS-1:0] stage;
  logic [CHANNELS-1:0] latch;
  logic [`SLD_SYNC_LEN-1:0] stb_sync;
  logic [`SLD_SYNC_LEN-1:0] blk_sync;
  logic stb_lvl;
  logic blk_lvl;

  // ****************************************
  // link domain shift register
  // ****************************************
  // shift on rising edge only
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[CHANNELS-2:0], link.sdi};
    end
  end

  // cascade output is the last stage itself
  assign link.sdo = stage[CHANNELS-1];

  // ****************************************
  // synchronisers for strobe and blank levels
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_sync <= '0;
      blk_sync <= '1;
    end else begin
      stb_sync <= {stb_sync[`SLD_SYNC_LEN-2:0], link.strobe};
      blk_sync <= {blk_sync[`SLD_SYNC_LEN-2:0], link.blank};
    end
  end

  // level changes once second and third stages agree
  // limitation: a strobe must span about three of these clock periods
  // and the link must stay quiet as long again after it falls
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_lvl <= 1'b0;
      blk_lvl <= 1'b1;
    end else begin
      if (stb_sync[1] == stb_sync[2]) begin
        stb_lvl <= stb_sync[2];
      end
      if (blk_sync[1] == blk_sync[2]) begin
        blk_lvl <= blk_sync[2];
      end
    end
  end

  // ****************************************
  // output latches
  // ****************************************
  // stages are quiet while strobe is high, so the word is stable
  // follow while strobe high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch <= '0;
    end else if (stb_lvl) begin
      latch <= stage;
    end
  end

  // ****************************************
  // output drivers
  // ****************************************
  // blank gates drivers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_o <= '0;
    end else if (blk_lvl) begin
      drv_o <= '0;
    end else begin
      drv_o <= latch;
    end
  end

endmodule : sld_device

`default_nettype wire

//--- verilog/sld_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sld_map.svh"

// ****************************************
// controller end: shifts a word and strobes it
// ****************************************
module sld_ctl
  import sld_pkg::*;
#(
  parameter int CHANNELS = `SLD_CHANNELS
) (
  sld_if.ctl link,
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [CHANNELS-1:0] data_i,
  input wire logic blank_i,
  output logic busy_o,
  output logic done_o
);

  localparam logic [`SLD_CNT_W-1:0] CYC_SCK = `SLD_CNT_W'(`SLD_CYC_SCK);
  localparam logic [`SLD_CNT_W-1:0] CYC_GAP = `SLD_CNT_W'(`SLD_CYC_GAP);
  localparam logic [`SLD_CNT_W-1:0] CYC_TAIL = `SLD_CNT_W'(`SLD_CYC_TAIL);
  localparam logic [`SLD_CNT_W-1:0] CYC_STB_ALL = `SLD_CNT_W'(`SLD_CYC_STB_HOLD + `SLD_CYC_TAIL);
  localparam logic [`SLD_CNT_W-1:0] LAST_BIT = `SLD_CNT_W'(CHANNELS - 1);

  sld_state_t state;
  logic [`SLD_CNT_W-1:0] cnt;
  logic [`SLD_CNT_W-1:0] bit_idx;
  logic [CHANNELS-1:0] word;
  logic cnt_end;
  logic last_bit;
  logic take;
  logic bit_next;

  // phase end, last bit, and the two events that move the word
  assign cnt_end = (cnt == `SLD_CNT_W'(1));
  assign last_bit = (bit_idx == LAST_BIT);
  assign take = (state == SLD_IDLE) && start_i;
  assign bit_next = (state == SLD_HIGH) && cnt_end && !last_bit;

  // ****************************************
  // sequencer state
  // ****************************************
  // a frame walks low, high per bit, then gap, then strobe with its tail
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SLD_IDLE;
    end else begin
      case (state)
        SLD_IDLE: begin
          if (start_i) begin
            state <= SLD_LOW;
          end
        end
        SLD_LOW: begin
          if (cnt_end) begin
            state <= SLD_HIGH;
          end
        end
        SLD_HIGH: begin
          if (cnt_end && last_bit) begin
            state <= SLD_GAP;
          end else if (cnt_end) begin
            state <= SLD_LOW;
          end
        end
        SLD_GAP: begin
          if (cnt_end) begin
            state <= SLD_STROBE;
          end
        end
        SLD_STROBE: begin
          if (cnt_end) begin
            state <= SLD_IDLE;
          end
        end
        default: begin
          state <= SLD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // phase counter
  // ****************************************
  // phase lengths by counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      case (state)
        SLD_IDLE: begin
          if (start_i) begin
            cnt <= CYC_SCK;
          end
        end
        SLD_LOW: begin
          if (cnt_end) begin
            cnt <= CYC_SCK;
          end else begin
            cnt <= cnt - `SLD_CNT_W'(1);
          end
        end
        SLD_HIGH: begin
          if (!cnt_end) begin
            cnt <= cnt - `SLD_CNT_W'(1);
          end else if (last_bit) begin
            cnt <= CYC_GAP;
          end else begin
            cnt <= CYC_SCK;
          end
        end
        SLD_GAP: begin
          if (cnt_end) begin
            cnt <= CYC_STB_ALL;
          end else begin
            cnt <= cnt - `SLD_CNT_W'(1);
          end
        end
        SLD_STROBE: begin
          if (!cnt_end) begin
            cnt <= cnt - `SLD_CNT_W'(1);
          end
        end
        default: begin
          cnt <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // bit counter and shift word
  // ****************************************
  // bit index restarts whenever the sequencer rests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_idx <= '0;
    end else if (state == SLD_IDLE) begin
      bit_idx <= '0;
    end else if (bit_next) begin
      bit_idx <= bit_idx + `SLD_CNT_W'(1);
    end
  end

  // word loads on take, moves one place after each high phase but the last
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word <= '0;
    end else if (take) begin
      word <= data_i;
    end else if (bit_next) begin
      word <= {word[CHANNELS-2:0], 1'b0};
    end
  end

  // ****************************************
  // link pins, all from flip-flops
  // ****************************************
  // data changes only at start of a low phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.sdi <= 1'b0;
    end else begin
      link.sdi <= word[CHANNELS-1];
    end
  end

  // clock high for the whole high phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.sclk <= 1'b0;
    end else begin
      link.sclk <= (state == SLD_HIGH);
    end
  end

  // strobe only pulses after loading, for the hold count
  // the low tail lets a slowly sampling receiver drop strobe before shifting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.strobe <= 1'b0;
    end else begin
      link.strobe <= (state == SLD_STROBE) && (cnt > CYC_TAIL);
    end
  end

  // blank follows the user level; drivers off from reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.blank <= 1'b1;
    end else begin
      link.blank <= blank_i;
    end
  end

  // ****************************************
  // user status
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= (state != SLD_IDLE) || start_i;
      done_o <= (state == SLD_STROBE) && cnt_end;
    end
  end

endmodule : sld_ctl

`default_nettype wire

//--- bench/sld_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// link timing checks
// ********
module sld_link_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic strobe,
  input wire logic blank
);
  logic [4:0] low_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since sclk was last high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt <= 5'h00;
    else if (sclk) low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
  end
  sequence s_high6; sclk [*6] ##1 !sclk; endsequence
  sequence s_low6; (!sclk) [*6]; endsequence
  sclk_high_width_a:
    assert property ($rose(sclk) |-> s_high6) else $error("sclk high phase wrong");
  sclk_low_width_a:
    assert property ($fell(sclk) |-> s_low6) else $error("sclk low phase short");
  sdi_hold_a:
    assert property ($rose(sclk) |-> $stable(sdi) [*6]) else $error("sdi moved near sclk edge");
  strobe_gap_a:
    assert property ($rose(strobe) |-> low_cnt >= 5'h0c) else $error("strobe too soon");
  strobe_clock_quiet_a:
    assert property (strobe |-> !sclk) else $error("sclk active under strobe");
  strobe_width_a:
    assert property ($rose(strobe) |-> strobe [*4]) else $error("strobe pulse short");
  strobe_blank_a:
    assert property (strobe |-> (blank || !sclk)) else $error("unblanked shift under strobe");
  sdo_idle_hold_a:
    assert property ($changed(sdo) |-> $rose(sclk)) else $error("sdo moved without sclk");
endmodule : sld_link_monitor
`default_nettype wire

//--- bench/serial_in_latched_output_driver_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// bench for both link ends
// ********
module serial_in_latched_output_driver_tb_top;
  logic clk_i = 1'b0;
  logic dev_clk = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic blank_i = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic busy_o;
  logic done_o;
  logic [7:0] drv_o;
  int err_total = 0;
  int checked = 0;
  sld_if link ();
  // system clock and unrelated device clock
  always #12.5 clk_i = ~clk_i;
  always #32 dev_clk = ~dev_clk;
  sld_ctl u_sld_ctl (.link(link.ctl), .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .data_i(data_i), .blank_i(blank_i), .busy_o(busy_o), .done_o(done_o));
  sld_device u_sld_device (.link(link.dev), .clk_i(dev_clk), .rst_n_i(rst_n_i), .drv_o(drv_o));
  sld_link_monitor u_sld_link_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
    .sdi(link.sdi), .sdo(link.sdo), .strobe(link.strobe), .blank(link.blank));
  // compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // let the device sync and latch settle
  task automatic settle();
    repeat (12) @(posedge dev_clk);
    @(negedge clk_i);
  endtask : settle
  // one word; junk is offered while busy; prev must stand mid-transfer
  task automatic send(input logic [7:0] d, input logic [7:0] junk, input logic [7:0] prev);
    int n;
    @(posedge clk_i);
    start_i <= 1'b1;
    data_i <= d;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(negedge clk_i);
    n = 0;
    while (done_o !== 1'b1) begin
      @(posedge clk_i);
      if (n == 20) start_i <= 1'b1;
      if (n == 20) data_i <= junk;
      if (n == 21) start_i <= 1'b0;
      @(negedge clk_i);
      n++;
      if (n == 1) chk("busy_run", 8'h01, {7'h00, busy_o});
      if (n == 60) chk("drv_mid", prev, drv_o);
      if (n == 300) begin
        err_total++;
        close_out();
      end
    end
    @(negedge clk_i);
    chk("busy_end", 8'h00, {7'h00, busy_o});
    chk("done_end", 8'h00, {7'h00, done_o});
  endtask : send
  task automatic t_basic();
    send(8'ha5, 8'h5a, 8'h00);
    settle();
    chk("drv_basic", 8'ha5, drv_o);
    chk("sdo_basic", 8'h01, {7'h00, link.sdo});
  endtask : t_basic
  task automatic t_b2b();
    send(8'h01, 8'h7e, 8'ha5);
    send(8'h80, 8'h7f, 8'h01);
    settle();
    chk("drv_b2b", 8'h80, drv_o);
    chk("sdo_b2b", 8'h01, {7'h00, link.sdo});
  endtask : t_b2b
  task automatic t_blank();
    @(posedge clk_i);
    blank_i <= 1'b1;
    send(8'h3c, 8'hc3, 8'h00);
    settle();
    chk("drv_blank", 8'h00, drv_o);
    @(posedge clk_i);
    blank_i <= 1'b0;
    settle();
    chk("drv_unblank", 8'h3c, drv_o);
    chk("sdo_unblank", 8'h00, {7'h00, link.sdo});
  endtask : t_blank
  // reset, then scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    chk("drv_rst", 8'h00, drv_o);
    t_basic();
    t_b2b();
    t_blank();
    close_out();
  end
endmodule : serial_in_latched_output_driver_tb_top
`default_nettype wire
